/* File: pkg/tpc4_pkg.sv */
// constants and types for the channel 4 pin-function control block
package tpc4_pkg;
  // ******************************************************
  // bus map
  // ******************************************************
  localparam int unsigned ADDR_W = 18; // byte address width
  localparam logic [17:0] CTRL_IDX = 18'h0fe92; // printed index
  localparam logic [17:0] CTRL_ADDR = {CTRL_IDX[15:0], 2'b00};
  localparam logic [17:0] GRA_ADDR = 18'h3fa4c; // general reg a
  localparam logic [17:0] GRB_ADDR = 18'h3fa50; // general reg b
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ******************************************************
  // control register layout
  // ******************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int unsigned SEL_W = 4; // one selector per register
  localparam int unsigned CAP_BIT = 3; // 1 = input capture
  localparam int unsigned SRC_BIT = 2; // init level, or cascade
  localparam logic [1:0] OC_OFF = 2'h0; // output disabled
  localparam logic [1:0] OC_LOW = 2'h1; // 0 at match
  localparam logic [1:0] OC_HIGH = 2'h2; // 1 at match
  localparam logic [1:0] OC_TOG = 2'h3; // toggle at match
  localparam int unsigned CNT_W = 16; // counter width
  localparam logic [15:0] GR_RESET = 16'hffff;
  // pin drive pair
  typedef struct packed {
    logic level; // driven level
    logic oe; // high while driving
  } tpc4_pin_drv_t;
  // write channel states
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } tpc4_wr_state_t;
endpackage

/* File: rtl/tpc4_top.sv */
// channel 4 pin-function control with capture/compare and axi4-lite
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// - 8-bit rw control, b high nibble, a low
// - top bit 0: compare, init level, 00 off
// - low bits 01: pin low at match
// - low bits 10: pin high at match
// - low bits 11: toggle pin at match
// - 1000: capture on pin rising edge
// - 1001: capture on pin falling edge
// - 101x: capture on both pin edges
// - 11xx: capture on channel 3 event
module tpc4_top (
  input wire logic clk_sys, // 200 mhz clock
  input wire logic rst, // sync reset, active high
  input wire logic [17:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [17:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [15:0] counter, // channel 4 counter value
  input wire logic ch3_a_event, // ch3 reg a match/capture pulse
  input wire logic ch3_c_event, // ch3 reg c match/capture pulse
  input wire logic ch4_pin_a_in, // pin a level
  input wire logic ch4_pin_b_in, // pin b level
  output tpc4_pkg::tpc4_pin_drv_t ch4_pin_a, // pin a drive
  output tpc4_pkg::tpc4_pin_drv_t ch4_pin_b // pin b drive
);
  // ******************************************************
  // state
  // ******************************************************
  tpc4_pkg::tpc4_wr_state_t wr_state; // write channel state
  logic aw_got; // write address held
  logic w_got; // write data held
  logic [17:0] waddr; // held write address
  logic [31:0] wdata; // held write data
  logic [3:0] wstrb; // held strobes
  logic [7:0] ch4_pin_function_control; // selectors b:a
  logic [15:0] gr [2]; // general registers a, b
  logic [1:0] pin_level; // driven levels
  logic [1:0] pin_oe; // drive enables
  logic [1:0] pin_prev; // last sampled pin levels
  logic [1:0] match_prev; // last compare result
  logic [1:0] oc_hit; // compare match event
  logic [1:0] cap_trig; // capture event
  logic wr_fire; // write performed this cycle
  logic ctrl_wr; // control register written
  logic [1:0] gr_wr; // general register written
  logic [31:0] next_rdata; // read mux
  logic [1:0] next_rresp; // read response mux
  wire [1:0] pin_in = {ch4_pin_b_in, ch4_pin_a_in};
  wire [1:0] casc = {ch3_c_event, ch3_a_event};
  assign wr_fire = (wr_state == tpc4_pkg::WR_IDLE) && aw_got && w_got;
  assign ctrl_wr = wr_fire && (waddr == tpc4_pkg::CTRL_ADDR) && wstrb[0];
  assign gr_wr[0] = wr_fire && (waddr == tpc4_pkg::GRA_ADDR);
  assign gr_wr[1] = wr_fire && (waddr == tpc4_pkg::GRB_ADDR);
  // ******************************************************
  // axi4-lite write channel
  // ******************************************************
  // address and data are taken in either order and held until the
  // write response is accepted; ready stays low while one is held
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_state <= tpc4_pkg::WR_IDLE;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr <= '0;
      wdata <= '0;
      wstrb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tpc4_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_got && ~(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= ~w_got && ~(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        waddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wdata <= s_axi_wdata;
        wstrb <= s_axi_wstrb;
      end
      unique case (wr_state)
        tpc4_pkg::WR_IDLE: begin
          if (aw_got && w_got) begin
            wr_state <= tpc4_pkg::WR_RESP;
            s_axi_bvalid <= 1'b1;
            // unmapped writes are answered with an error
            s_axi_bresp <= (ctrl_wr || gr_wr != 2'b00 ||
                waddr == tpc4_pkg::CTRL_ADDR) ?
                tpc4_pkg::RESP_OKAY : tpc4_pkg::RESP_SLVERR;
          end
        end
        tpc4_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= tpc4_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
          end
        end
      endcase
    end
  end
  // ******************************************************
  // axi4-lite read channel
  // ******************************************************
  // read mux; upper bits read as zero
  always_comb begin
    next_rdata = '0;
    next_rresp = tpc4_pkg::RESP_OKAY;
    if (s_axi_araddr == tpc4_pkg::CTRL_ADDR) begin
      next_rdata[7:0] = ch4_pin_function_control;
    end else if (s_axi_araddr == tpc4_pkg::GRA_ADDR) begin
      next_rdata[15:0] = gr[0];
    end else if (s_axi_araddr == tpc4_pkg::GRB_ADDR) begin
      next_rdata[15:0] = gr[1];
    end else begin
      next_rresp = tpc4_pkg::RESP_SLVERR;
    end
  end
  // one read at a time; arready drops while the answer waits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= tpc4_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
  // ******************************************************
  // control register
  // ******************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ch4_pin_function_control <= tpc4_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ch4_pin_function_control <= wdata[7:0];
    end
  end
  // ******************************************************
  // per register compare and capture
  // ******************************************************
  for (genvar i = 0; i < 2; i++) begin : g_ch
    wire [3:0] sel = ch4_pin_function_control[i*tpc4_pkg::SEL_W +:
        tpc4_pkg::SEL_W];
    wire [3:0] new_sel = wdata[i*tpc4_pkg::SEL_W +: tpc4_pkg::SEL_W];
    wire is_cap = sel[tpc4_pkg::CAP_BIT];
    wire rise = pin_in[i] && ~pin_prev[i];
    wire fall = ~pin_in[i] && pin_prev[i];
    wire match = (counter == gr[i]);
    // a match that lasts many cycles fires only once
    assign oc_hit[i] = ~is_cap && match && ~match_prev[i];
    // edge choice, or the channel 3 event in cascade
    assign cap_trig[i] = is_cap && (sel[tpc4_pkg::SRC_BIT] ? casc[i] :
        sel[1] ? (rise || fall) :
        sel[0] ? fall : rise);
    // sampling pins and compare result for edge detection
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        pin_prev[i] <= 1'b0;
        match_prev[i] <= 1'b0;
      end else begin
        pin_prev[i] <= pin_in[i];
        match_prev[i] <= match;
      end
    end
    // capture wins over a software write in the same cycle
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        gr[i] <= tpc4_pkg::GR_RESET;
      end else if (cap_trig[i]) begin
        gr[i] <= counter;
      end else if (gr_wr[i]) begin
        if (wstrb[0]) begin
          gr[i][7:0] <= wdata[7:0];
        end
        if (wstrb[1]) begin
          gr[i][15:8] <= wdata[15:8];
        end
      end
    end
    // pin level: initial level on selector write, then match action
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        pin_level[i] <= 1'b0;
        pin_oe[i] <= 1'b0;
      end else begin
        pin_oe[i] <= ~is_cap && (sel[1:0] != tpc4_pkg::OC_OFF);
        if (ctrl_wr && ~new_sel[tpc4_pkg::CAP_BIT]) begin
          pin_level[i] <= new_sel[tpc4_pkg::SRC_BIT];
        end else if (oc_hit[i]) begin
          unique case (sel[1:0])
            tpc4_pkg::OC_OFF: pin_level[i] <= pin_level[i];
            tpc4_pkg::OC_LOW: pin_level[i] <= 1'b0;
            tpc4_pkg::OC_HIGH: pin_level[i] <= 1'b1;
            tpc4_pkg::OC_TOG: pin_level[i] <= ~pin_level[i];
          endcase
        end
      end
    end
  end
  assign ch4_pin_a = '{level: pin_level[0], oe: pin_oe[0]};
  assign ch4_pin_b = '{level: pin_level[1], oe: pin_oe[1]};
  // ******************************************************
  // assertions
  // ******************************************************
  wire [3:0] sa = ch4_pin_function_control[3:0];
  wire [3:0] sb = ch4_pin_function_control[7:4];
  property p_ctrl_rst;
    @(posedge clk_sys) rst |=> ch4_pin_function_control == 8'h00;
  endproperty
  a_ctrl_rst: assert property (p_ctrl_rst) else $error("ctrl reset");
  property p_ctrl_wr;
    @(posedge clk_sys) disable iff (rst)
      ctrl_wr |=> ch4_pin_function_control == $past(wdata[7:0]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("ctrl write");
  property p_init;
    @(posedge clk_sys) disable iff (rst)
      ctrl_wr && !wdata[3] |=> pin_level[0] == $past(wdata[2]);
  endproperty
  a_init: assert property (p_init) else $error("initial level");
  property p_off;
    @(posedge clk_sys) disable iff (rst)
      (sa[3:2] == 2'h0 && sa[1:0] == 2'h0) [*2] |-> !ch4_pin_a.oe;
  endproperty
  a_off: assert property (p_off) else $error("pin driven while off");
  property p_low;
    @(posedge clk_sys) disable iff (rst)
      oc_hit[0] && sa[1:0] == 2'h1 && !ctrl_wr |=> !pin_level[0];
  endproperty
  a_low: assert property (p_low) else $error("match low");
  property p_high;
    @(posedge clk_sys) disable iff (rst)
      oc_hit[1] && sb[1:0] == 2'h2 && !ctrl_wr |=> pin_level[1];
  endproperty
  a_high: assert property (p_high) else $error("match high");
  property p_tog;
    @(posedge clk_sys) disable iff (rst)
      oc_hit[0] && sa[1:0] == 2'h3 && !ctrl_wr |=>
        pin_level[0] != $past(pin_level[0]);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle");
  property p_rise;
    @(posedge clk_sys) disable iff (rst)
      sa == 4'h8 && $rose(ch4_pin_a_in) |-> ##1 gr[0] == $past(counter);
  endproperty
  a_rise: assert property (p_rise) else $error("rise capture");
  property p_fall;
    @(posedge clk_sys) disable iff (rst)
      sb == 4'h9 && $fell(ch4_pin_b_in) |-> ##1 gr[1] == $past(counter);
  endproperty
  a_fall: assert property (p_fall) else $error("fall capture");
  property p_both;
    @(posedge clk_sys) disable iff (rst)
      sa[3:1] == 3'h5 && ($past(ch4_pin_a_in) != ch4_pin_a_in) |=>
        gr[0] == $past(counter);
  endproperty
  a_both: assert property (p_both) else $error("both capture");
  property p_casc;
    @(posedge clk_sys) disable iff (rst)
      sb[3:2] == 2'h3 && ch3_c_event |=> gr[1] == $past(counter);
  endproperty
  a_casc: assert property (p_casc) else $error("cascade capture");
  c_tog: cover property (@(posedge clk_sys) oc_hit[0] && sa[1:0] == 2'h3);
  c_casc: cover property (@(posedge clk_sys) cap_trig[1] && sb[2]);
  c_wr: cover property (@(posedge clk_sys) s_axi_bvalid && s_axi_bready);
  c_rd: cover property (@(posedge clk_sys) s_axi_rvalid && s_axi_rready);
endmodule

/* File: verification/tpc4_pin_model.sv */
// outside circuit on the two channel 4 timer pins
`timescale 1ns/1ps
// ******************************************************
// pin wire resolution
// ******************************************************
module tpc4_pin_model (
  input wire tpc4_pkg::tpc4_pin_drv_t drv_a, // block drive on pin a
  input wire tpc4_pkg::tpc4_pin_drv_t drv_b, // block drive on pin b
  input wire logic ext_a, // level the outside applies to pin a
  input wire logic ext_b, // level the outside applies to pin b
  output logic pin_a, // resolved level of pin a
  output logic pin_b // resolved level of pin b
);
  // the block owns the wire while it drives; the outside source is weak
  // so a driving block never fights it, and the bench sees its level
  assign pin_a = drv_a.oe ? drv_a.level : ext_a;
  // same resolution for pin b
  assign pin_b = drv_b.oe ? drv_b.level : ext_b;
endmodule

/* File: verification/tb.sv */
// self-checking bench for the channel 4 pin-function control block
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0; // 200 mhz clock
  logic rst = 1'b1; // sync reset
  logic [17:0] s_axi_awaddr = 18'h0; // write address
  logic s_axi_awvalid = 1'b0; // write address valid
  logic [31:0] s_axi_wdata = 32'h0; // write data
  logic [3:0] s_axi_wstrb = 4'h0; // byte strobes
  logic s_axi_wvalid = 1'b0; // write data valid
  logic s_axi_bready = 1'b0; // response ready
  logic [17:0] s_axi_araddr = 18'h0; // read address
  logic s_axi_arvalid = 1'b0; // read address valid
  logic s_axi_rready = 1'b0; // read data ready
  logic [15:0] counter = 16'h0; // channel 4 counter
  logic ch3_a_event = 1'b0; // channel 3 a event
  logic ch3_c_event = 1'b0; // channel 3 c event
  logic ext_a = 1'b0; // outside level on pin a
  logic ext_b = 1'b0; // outside level on pin b
  logic awready, wready, bvalid, arready, rvalid; // bus answers
  logic [1:0] bresp, rresp; // response codes
  logic [31:0] rdata; // read data
  logic pin_a_in, pin_b_in; // resolved pins
  tpc4_pkg::tpc4_pin_drv_t ch4_pin_a, ch4_pin_b; // pin drives
  int bad_count = 0; // mismatches
  int n_checks = 0; // comparisons
  // compare rows: sel, -, init level, level after match, oe
  logic [7:0] cmp_rows [8] = '{8'h00, 8'h11, 8'h23, 8'h33,
                               8'h46, 8'h55, 8'h67, 8'h75};
  // capture rows: sel, pin before, pin after, ev a, ev c, cap a, cap b
  logic [9:0] cap_rows [10] = '{10'h213, 10'h220, 10'h263, 10'h250,
    10'h293, 10'h2e3, 10'h310, 10'h34a, 10'h3c5, 10'h20c};
  always #2.5 clk_sys = ~clk_sys;
  tpc4_top DUT (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(s_axi_rready), .counter(counter),
    .ch3_a_event(ch3_a_event), .ch3_c_event(ch3_c_event),
    .ch4_pin_a_in(pin_a_in), .ch4_pin_b_in(pin_b_in),
    .ch4_pin_a(ch4_pin_a), .ch4_pin_b(ch4_pin_b));
  tpc4_pin_model pins (.drv_a(ch4_pin_a), .drv_b(ch4_pin_b), .ext_a(ext_a),
    .ext_b(ext_b), .pin_a(pin_a_in), .pin_b(pin_b_in));
  // ******************************************************
  // bus and compare tasks
  // ******************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one write; address and data are released as each is taken
  task automatic axw(input logic [17:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // one read; rready is held until the data is seen
  task automatic axr(input logic [17:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // full-word write that must be accepted
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, 4'hf, r);
    chk({30'h0, r}, {30'h0, tpc4_pkg::RESP_OKAY});
  endtask
  task automatic rdchk(input logic [17:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, tpc4_pkg::RESP_OKAY});
  endtask
  // both pins as {oe, level} pairs
  task automatic pin_chk(input logic [1:0] ea, input logic [1:0] eb);
    chk({28'h0, ch4_pin_a.oe, ch4_pin_a.level, ch4_pin_b.oe,
         ch4_pin_b.level}, {28'h0, ea, eb});
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ******************************************************
  // main sequence
  // ******************************************************
  initial begin
    logic [9:0] row;
    logic [31:0] d;
    logic [1:0] r;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    wr(tpc4_pkg::GRA_ADDR, 32'h40);
    wr(tpc4_pkg::GRB_ADDR, 32'h40);
    // every compare mode on both selectors; match held 3 cycles acts once
    for (int i = 0; i < 8; i++) begin
      wr(tpc4_pkg::CTRL_ADDR, {24'h0, cmp_rows[i][7:4], cmp_rows[i][7:4]});
      repeat (3) @(posedge clk_sys);
      pin_chk({cmp_rows[i][0], cmp_rows[i][2]},
              {cmp_rows[i][0], cmp_rows[i][2]});
      counter <= 16'h0040;
      repeat (3) @(posedge clk_sys);
      counter <= 16'h0000;
      repeat (3) @(posedge clk_sys);
      pin_chk({cmp_rows[i][0], cmp_rows[i][1]},
              {cmp_rows[i][0], cmp_rows[i][1]});
    end
    // capture modes; counter value lands only where the trigger fits
    for (int i = 0; i < 10; i++) begin
      row = cap_rows[i];
      @(posedge clk_sys);
      ext_a <= row[5];
      ext_b <= row[5];
      wr(tpc4_pkg::CTRL_ADDR, {24'h0, row[9:6], row[9:6]});
      wr(tpc4_pkg::GRA_ADDR, 32'h1234);
      wr(tpc4_pkg::GRB_ADDR, 32'h1234);
      repeat (3) @(posedge clk_sys);
      chk({30'h0, ch4_pin_a.oe, ch4_pin_b.oe}, 32'h0);
      ext_a <= row[4];
      ext_b <= row[4];
      counter <= 16'h5a5a;
      ch3_a_event <= row[3];
      ch3_c_event <= row[2];
      @(posedge clk_sys);
      ch3_a_event <= 1'b0;
      ch3_c_event <= 1'b0;
      repeat (3) @(posedge clk_sys);
      counter <= 16'h0000;
      rdchk(tpc4_pkg::GRA_ADDR, row[1] ? 32'h5a5a : 32'h1234);
      rdchk(tpc4_pkg::GRB_ADDR, row[0] ? 32'h5a5a : 32'h1234);
    end
    // unmapped address is refused and reads zero
    axw(18'h00010, 32'h1, 4'hf, r);
    chk({30'h0, r}, {30'h0, tpc4_pkg::RESP_SLVERR});
    axr(18'h00010, d, r);
    chk({30'h0, r}, {30'h0, tpc4_pkg::RESP_SLVERR});
    chk(d, 32'h0);
    // read back, upper bits zero; a write without lane 0 changes nothing
    wr(tpc4_pkg::CTRL_ADDR, 32'hffff_ffa5);
    rdchk(tpc4_pkg::CTRL_ADDR, 32'h0000_00a5);
    axw(tpc4_pkg::CTRL_ADDR, 32'h0000_005a, 4'he, r);
    chk({30'h0, r}, {30'h0, tpc4_pkg::RESP_OKAY});
    rdchk(tpc4_pkg::CTRL_ADDR, 32'h0000_00a5);
    // nibbles reach their own pins: a compare low, b off at level 1
    wr(tpc4_pkg::CTRL_ADDR, 32'h0000_0041);
    repeat (3) @(posedge clk_sys);
    pin_chk(2'h2, 2'h1);
    // reset in mid-run clears control and pin drive and sets the general regs to ffff
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk(tpc4_pkg::CTRL_ADDR, 32'h0);
    rdchk(tpc4_pkg::GRA_ADDR, 32'h0000_ffff);
    rdchk(tpc4_pkg::GRB_ADDR, 32'h0000_ffff);
    pin_chk(2'h0, 2'h0);
    print_verdict();
  end
  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end
endmodule
